// ===== hdl/flm_pkg.sv
package flm_pkg;
  // command codes on the management port
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VOUT_UV_LIM = 8'h44;
  localparam logic [7:0] CMD_VOUT_UV_ACT = 8'h45;
  localparam logic [7:0] CMD_IOUT_OC_LIM = 8'h46;
  localparam logic [7:0] CMD_IOUT_OC_ACT = 8'h47;
  localparam logic [7:0] CMD_OC_LV_LIM = 8'h48;
  localparam logic [7:0] CMD_OC_LV_ACT = 8'h49;
  localparam logic [7:0] CMD_IOUT_OCW_LIM = 8'h4a;
  localparam logic [7:0] CMD_SINK_LIM = 8'h4b;
  localparam logic [7:0] CMD_SINK_ACT = 8'h4c;
  localparam logic [7:0] CMD_OT_LIM = 8'h4f;
  localparam logic [7:0] CMD_OT_ACT = 8'h50;
  localparam logic [7:0] CMD_OTW_LIM = 8'h51;
  localparam logic [7:0] CMD_UTW_LIM = 8'h52;
  localparam logic [7:0] CMD_UT_LIM = 8'h53;
  localparam logic [7:0] CMD_UT_ACT = 8'h54;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;
  localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
  // status byte bit positions
  localparam int SB_IOUT_OC = 4;
  localparam int SB_TEMP = 2;
  localparam int SB_OTHER = 0;
  // status word high byte bit positions
  localparam int SW_VOUT = 7;
  localparam int SW_IOUT = 6;
  // status vout / iout / temperature bit positions
  localparam int SV_UV_FAULT = 4;
  localparam int SI_OC_FAULT = 7;
  localparam int SI_OC_LV_FAULT = 6;
  localparam int SI_OC_WARN = 5;
  localparam int SI_UC_FAULT = 4;
  localparam int ST_OT_FAULT = 7;
  localparam int ST_OT_WARN = 6;
  localparam int ST_UT_WARN = 5;
  localparam int ST_UT_FAULT = 4;
  // reset values
  localparam logic [15:0] LIM_ZERO_RST = 16'h0000;
  localparam logic [15:0] OC_LIM_RST = 16'h7fff;
  localparam logic [15:0] OT_LIM_RST = 16'h7fff;
  localparam logic [15:0] UT_LIM_RST = 16'h8000;
  localparam logic [7:0] ACT_RST = 8'h00;
  // response action byte: bits 7:6 code, 5:3 retry, 2:0 delay
  localparam logic [1:0] ACT_IGNORE = 2'b00;
  localparam logic [1:0] ACT_CONST_CUR = 2'b01;
  localparam logic [1:0] ACT_DELAY_OFF = 2'b10;
  localparam logic [1:0] ACT_INHIBIT = 2'b11;
  // delay unit, fixed for the device
  localparam int DELAY_UNIT_US = 100;
  localparam int CLK_MHZ = 20;
  localparam int DELAY_UNIT_CYC = DELAY_UNIT_US * CLK_MHZ;
  localparam int DIV_W = 12;
endpackage

// ===== hdl/flm_top.sv
module flm_top (
  input wire logic clk, // core clock
  input wire logic sys_rst, // sync reset, high
  input wire logic cmd_wr, // write strobe
  input wire logic [7:0] cmd_code, // command code
  input wire logic [15:0] cmd_wdata, // write data
  output logic [15:0] cmd_rdata, // read data
  output logic cmd_ack, // command known
  input wire logic unit_en, // unit enabled
  input wire logic vout_in_reg, // output reached target
  input wire logic [15:0] meas_vout, // output voltage, vout mode
  input wire logic signed [15:0] meas_iout, // output current, sink negative
  input wire logic signed [15:0] meas_temp, // temperature
  output logic fault_alert, // fault notification
  output logic warn_alert, // warning notification
  output logic [1:0] fault_act, // action code in force
  output logic out_off, // stop energy transfer
  output logic sync_rect_off, // stop synchronous rectifier
  output logic cur_limit // constant current mode
);
  import flm_pkg::*;

  // ==========================================
  // settings
  logic [15:0] uv_lim_q, oc_lim_q, lv_lim_q, ocw_lim_q, sink_lim_q;
  logic signed [15:0] ot_lim_q, otw_lim_q, utw_lim_q, ut_lim_q;
  logic [7:0] uv_act_q, oc_act_q, lv_act_q, sink_act_q, ot_act_q, ut_act_q;
  logic uv_armed_q;

  wire clr = cmd_wr && cmd_code == CMD_CLEAR_FAULTS;
  wire wr_uv = cmd_wr && cmd_code == CMD_VOUT_UV_LIM;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uv_lim_q <= LIM_ZERO_RST;
      lv_lim_q <= LIM_ZERO_RST;
      sink_lim_q <= LIM_ZERO_RST;
      oc_lim_q <= OC_LIM_RST;
      ocw_lim_q <= OC_LIM_RST;
      ot_lim_q <= OT_LIM_RST;
      otw_lim_q <= OT_LIM_RST;
      utw_lim_q <= UT_LIM_RST;
      ut_lim_q <= UT_LIM_RST;
      uv_act_q <= ACT_RST;
      oc_act_q <= ACT_RST;
      lv_act_q <= ACT_RST;
      sink_act_q <= ACT_RST;
      ot_act_q <= ACT_RST;
      ut_act_q <= ACT_RST;
    end else if (cmd_wr) begin
      case (cmd_code)
        CMD_VOUT_UV_LIM: uv_lim_q <= cmd_wdata;
        CMD_IOUT_OC_LIM: oc_lim_q <= cmd_wdata;
        CMD_OC_LV_LIM: lv_lim_q <= cmd_wdata;
        CMD_IOUT_OCW_LIM: ocw_lim_q <= cmd_wdata;
        CMD_SINK_LIM: sink_lim_q <= cmd_wdata;
        CMD_OT_LIM: ot_lim_q <= cmd_wdata;
        CMD_OTW_LIM: otw_lim_q <= cmd_wdata;
        CMD_UTW_LIM: utw_lim_q <= cmd_wdata;
        CMD_UT_LIM: ut_lim_q <= cmd_wdata;
        CMD_VOUT_UV_ACT: uv_act_q <= cmd_wdata[7:0];
        CMD_IOUT_OC_ACT: oc_act_q <= cmd_wdata[7:0];
        CMD_OC_LV_ACT: lv_act_q <= cmd_wdata[7:0];
        CMD_SINK_ACT: sink_act_q <= cmd_wdata[7:0];
        CMD_OT_ACT: ot_act_q <= cmd_wdata[7:0];
        CMD_UT_ACT: ut_act_q <= cmd_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // undervoltage arming
  always_ff @(posedge clk) begin
    if (sys_rst || !unit_en) begin
      uv_armed_q <= 1'b0;
    end else if (vout_in_reg) begin
      uv_armed_q <= 1'b1;
    end
  end

  // ==========================================
  // comparators
  wire signed [16:0] sink_neg = -$signed({1'b0, sink_lim_q});
  wire uv_det = uv_armed_q && unit_en && meas_vout < uv_lim_q;
  wire oc_over = meas_iout > $signed({1'b0, oc_lim_q[14:0]});
  wire cc_mode = oc_act_q[7:6] == ACT_CONST_CUR;
  wire lv_low = meas_vout < lv_lim_q;
  wire oc_lv_det = oc_over && cc_mode && lv_low;
  wire oc_det = oc_over && !oc_lv_det;
  wire ocw_det = meas_iout > $signed({1'b0, ocw_lim_q[14:0]});
  wire sink_det = 17'(meas_iout) < sink_neg;
  wire ot_det = meas_temp > ot_lim_q;
  wire otw_det = meas_temp > otw_lim_q;
  wire utw_det = meas_temp < utw_lim_q;
  wire ut_det = meas_temp < ut_lim_q;

  // ==========================================
  // status registers; set wins over clear
  logic [7:0] sb_q, sw_q, sv_q, si_q, st_q;
  logic [7:0] sb_set, sw_set, sv_set, si_set, st_set;

  always_comb begin
    sb_set = 8'h00;
    sw_set = 8'h00;
    sv_set = 8'h00;
    si_set = 8'h00;
    st_set = 8'h00;
    sb_set[SB_OTHER] = uv_det || ocw_det || sink_det;
    sb_set[SB_IOUT_OC] = oc_det || oc_lv_det;
    sb_set[SB_TEMP] = ot_det || otw_det || utw_det || ut_det;
    sw_set[SW_VOUT] = uv_det;
    sw_set[SW_IOUT] = oc_det || oc_lv_det || ocw_det || sink_det;
    sv_set[SV_UV_FAULT] = uv_det;
    si_set[SI_OC_FAULT] = oc_det;
    si_set[SI_OC_LV_FAULT] = oc_lv_det;
    si_set[SI_OC_WARN] = ocw_det;
    si_set[SI_UC_FAULT] = sink_det;
    st_set[ST_OT_FAULT] = ot_det;
    st_set[ST_OT_WARN] = otw_det;
    st_set[ST_UT_WARN] = utw_det;
    st_set[ST_UT_FAULT] = ut_det;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sb_q <= 8'h00;
      sw_q <= 8'h00;
      sv_q <= 8'h00;
      si_q <= 8'h00;
      st_q <= 8'h00;
    end else begin
      sb_q <= (clr ? 8'h00 : sb_q) | sb_set;
      sw_q <= (clr ? 8'h00 : sw_q) | sw_set;
      sv_q <= (clr ? 8'h00 : sv_q) | sv_set;
      si_q <= (clr ? 8'h00 : si_q) | si_set;
      st_q <= (clr ? 8'h00 : st_q) | st_set;
    end
  end

  wire any_fault = sv_q[SV_UV_FAULT] || si_q[SI_OC_FAULT] || si_q[SI_OC_LV_FAULT]
    || si_q[SI_UC_FAULT] || st_q[ST_OT_FAULT] || st_q[ST_UT_FAULT];
  wire any_warn = si_q[SI_OC_WARN] || st_q[ST_OT_WARN] || st_q[ST_UT_WARN];
  assign fault_alert = any_fault;
  assign warn_alert = any_warn;

  // ==========================================
  // response actions with delay in fixed units
  logic [7:0] act_sel;
  assign act_sel = oc_lv_det ? lv_act_q : oc_det ? oc_act_q : uv_det ? uv_act_q :
    ot_det ? ot_act_q : ut_det ? ut_act_q : sink_det ? sink_act_q : ACT_RST;
  wire sink_only = sink_det && !(oc_lv_det || oc_det || uv_det || ot_det || ut_det);

  logic [DIV_W-1:0] div_q;
  logic [2:0] dly_q;
  logic [1:0] fault_act_q;
  logic sink_q;
  wire tick = div_q == DIV_W'(DELAY_UNIT_CYC - 1);
  wire active = act_sel[7:6] != ACT_IGNORE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= '0;
      dly_q <= 3'd0;
      fault_act_q <= ACT_IGNORE;
      sink_q <= 1'b0;
    end else if (!active) begin
      div_q <= '0;
      dly_q <= 3'd0;
      fault_act_q <= ACT_IGNORE;
      sink_q <= 1'b0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      if (act_sel[7:6] != ACT_DELAY_OFF || dly_q >= act_sel[2:0]) begin
        fault_act_q <= act_sel[7:6];
        sink_q <= sink_only;
      end else if (tick) begin
        dly_q <= dly_q + 3'd1;
      end
    end
  end

  assign fault_act = fault_act_q;
  assign cur_limit = fault_act_q == ACT_CONST_CUR;
  assign out_off = (fault_act_q == ACT_DELAY_OFF || fault_act_q == ACT_INHIBIT) && !sink_q;
  assign sync_rect_off = fault_act_q == ACT_INHIBIT && sink_q;

  // ==========================================
  // read back
  always_comb begin
    cmd_ack = 1'b1;
    case (cmd_code)
      CMD_VOUT_UV_LIM: cmd_rdata = uv_lim_q;
      CMD_IOUT_OC_LIM: cmd_rdata = oc_lim_q;
      CMD_OC_LV_LIM: cmd_rdata = lv_lim_q;
      CMD_IOUT_OCW_LIM: cmd_rdata = ocw_lim_q;
      CMD_SINK_LIM: cmd_rdata = sink_lim_q;
      CMD_OT_LIM: cmd_rdata = ot_lim_q;
      CMD_OTW_LIM: cmd_rdata = otw_lim_q;
      CMD_UTW_LIM: cmd_rdata = utw_lim_q;
      CMD_UT_LIM: cmd_rdata = ut_lim_q;
      CMD_VOUT_UV_ACT: cmd_rdata = {8'h00, uv_act_q};
      CMD_IOUT_OC_ACT: cmd_rdata = {8'h00, oc_act_q};
      CMD_OC_LV_ACT: cmd_rdata = {8'h00, lv_act_q};
      CMD_SINK_ACT: cmd_rdata = {8'h00, sink_act_q};
      CMD_OT_ACT: cmd_rdata = {8'h00, ot_act_q};
      CMD_UT_ACT: cmd_rdata = {8'h00, ut_act_q};
      CMD_STATUS_BYTE: cmd_rdata = {8'h00, sb_q};
      CMD_STATUS_WORD: cmd_rdata = {sw_q, sb_q};
      CMD_STATUS_VOUT: cmd_rdata = {8'h00, sv_q};
      CMD_STATUS_IOUT: cmd_rdata = {8'h00, si_q};
      CMD_STATUS_TEMP: cmd_rdata = {8'h00, st_q};
      CMD_CLEAR_FAULTS: cmd_rdata = 16'h0000;
      default: begin
        cmd_rdata = 16'h0000;
        cmd_ack = 1'b0;
      end
    endcase
  end

  // ==========================================
  // checks
  property p_uv_masked;
    @(posedge clk) disable iff (sys_rst) !unit_en |=> !sv_set[SV_UV_FAULT];
  endproperty
  a_uv_masked: assert property (p_uv_masked) else $error("uv set while disabled");

  property p_uv_rst;
    @(posedge clk) $fell(sys_rst) |-> uv_lim_q == 16'h0000 && lv_lim_q == 16'h0000;
  endproperty
  a_uv_rst: assert property (p_uv_rst) else $error("voltage limits not zero");

  property p_uv_status;
    @(posedge clk) disable iff (sys_rst)
      uv_det |=> sv_q[SV_UV_FAULT] && sw_q[SW_VOUT] && sb_q[SB_OTHER] && fault_alert;
  endproperty
  a_uv_status: assert property (p_uv_status) else $error("uv status missing");

  property p_oc_status;
    @(posedge clk) disable iff (sys_rst)
      (meas_iout > $signed({1'b0, oc_lim_q[14:0]})) |=> sb_q[SB_IOUT_OC] && sw_q[SW_IOUT];
  endproperty
  a_oc_status: assert property (p_oc_status) else $error("oc status missing");

  property p_oc_lv;
    @(posedge clk) disable iff (sys_rst)
      oc_over && cc_mode && lv_low |=> si_q[SI_OC_LV_FAULT];
  endproperty
  a_oc_lv: assert property (p_oc_lv) else $error("oc lv bit missing");

  property p_ocw;
    @(posedge clk) disable iff (sys_rst) ocw_det |=> si_q[SI_OC_WARN] && warn_alert;
  endproperty
  a_ocw: assert property (p_ocw) else $error("oc warning missing");

  property p_sink;
    @(posedge clk) disable iff (sys_rst)
      (-17'(meas_iout) > $signed({1'b0, sink_lim_q})) |=> si_q[SI_UC_FAULT];
  endproperty
  a_sink: assert property (p_sink) else $error("sink fault missing");

  property p_sink_inhibit;
    @(posedge clk) disable iff (sys_rst)
      sink_only && sink_act_q[7:6] == ACT_INHIBIT |=> sync_rect_off && !out_off;
  endproperty
  a_sink_inhibit: assert property (p_sink_inhibit) else $error("sink turned off output");

  property p_temp;
    @(posedge clk) disable iff (sys_rst)
      meas_temp > ot_lim_q |=> st_q[ST_OT_FAULT] && sb_q[SB_TEMP];
  endproperty
  a_temp: assert property (p_temp) else $error("ot status missing");

  property p_clear;
    @(posedge clk) disable iff (sys_rst)
      clr && si_set == 8'h00 && !oc_over |=> si_q == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
endmodule

// ===== bench/flm_host.sv
module flm_host (
  input wire logic clk, // core clock
  output logic cmd_wr, // write strobe
  output logic [7:0] cmd_code, // command code
  output logic [15:0] cmd_wdata // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_wr = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one-cycle strobe, data scrambled once released
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_wdata = ~d;
  endtask
  task automatic sel(input logic [7:0] c);
    @(negedge clk);
    cmd_code = c;
  endtask
endmodule

// ===== bench/fault_limit_monitor_test.sv
module fault_limit_monitor_test
  import flm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, unit_en, vout_in_reg, cmd_wr, cmd_ack, fault_alert, warn_alert;
  logic out_off, sync_rect_off, cur_limit, rd_req;
  logic [1:0] fault_act;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, meas_vout, d;
  logic signed [15:0] meas_iout, meas_temp;
  logic [31:0] exp_q[$];
  logic [31:0] mon_e;
  int errors, checked, cyc, seed;
  logic [7:0] cd [15] = '{CMD_VOUT_UV_LIM, CMD_VOUT_UV_ACT, CMD_IOUT_OC_LIM, CMD_IOUT_OC_ACT,
    CMD_OC_LV_LIM, CMD_OC_LV_ACT, CMD_IOUT_OCW_LIM, CMD_SINK_LIM, CMD_SINK_ACT, CMD_OT_LIM,
    CMD_OT_ACT, CMD_OTW_LIM, CMD_UTW_LIM, CMD_UT_LIM, CMD_UT_ACT};
  logic [15:0] rv [15] = '{16'h0000, 16'h0000, OC_LIM_RST, 16'h0000, 16'h0000, 16'h0000,
    OC_LIM_RST, 16'h0000, 16'h0000, OT_LIM_RST, 16'h0000, OT_LIM_RST, UT_LIM_RST,
    UT_LIM_RST, 16'h0000};
  logic [0:14] ia = 15'b010101001010001;

  flm_host flm_host_i (.clk(clk), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  flm_top flm_top_i (.clk(clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .unit_en(unit_en),
    .vout_in_reg(vout_in_reg), .meas_vout(meas_vout), .meas_iout(meas_iout),
    .meas_temp(meas_temp), .fault_alert(fault_alert), .warn_alert(warn_alert),
    .fault_act(fault_act), .out_off(out_off), .sync_rect_off(sync_rect_off),
    .cur_limit(cur_limit));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================
  // checking and closing
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_req && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      chk(cmd_rdata & mon_e[31:16], mon_e[15:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end

  // ==========================================
  // host access and measurements
  task automatic wr(input logic [7:0] c, input logic [15:0] dv);
    flm_host_i.wr(c, dv);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic [15:0] m);
    flm_host_i.sel(c);
    exp_q.push_back({m, e});
    rd_req = 1'b1;
    @(negedge clk);
    rd_req = 1'b0;
  endtask
  task automatic meas(input logic [15:0] v, input logic [15:0] i, input logic [15:0] t);
    @(negedge clk);
    meas_vout = v;
    meas_iout = i;
    meas_temp = t;
    repeat (2) @(negedge clk);
  endtask
  task automatic idle;
    meas(16'h1000, 16'h0000, 16'h0020);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
  endtask

  // ==========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    unit_en = 1'b0;
    vout_in_reg = 1'b0;
    meas_vout = 16'h1000;
    meas_iout = 16'sh0000;
    meas_temp = 16'sh0020;
    rd_req = 1'b0;
    seed = 32'h3d14;
    errors = 0;
    checked = 0;
    cyc = 0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (int k = 0; k < 15; k++) begin
      d = 16'($random(seed));
      if (ia[k])
        d[15:8] = 8'h00;
      wr(cd[k], d);
      rd(cd[k], d, 16'hffff);
    end
    chk({15'h0000, cmd_ack}, 16'h0001);
    rd(8'hff, 16'h0000, 16'hffff);
    chk({15'h0000, cmd_ack}, 16'h0000);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (int k = 0; k < 15; k++)
      rd(cd[k], rv[k], 16'hffff);
    // overcurrent, constant current reaction, then low-voltage overcurrent with inhibit
    wr(CMD_IOUT_OC_ACT, 16'h0040);
    wr(CMD_IOUT_OC_LIM, 16'h0100);
    meas(16'h1000, 16'h0100, 16'h0020);
    rd(CMD_STATUS_BYTE, 16'h0000, 16'hffff);
    meas(16'h1000, 16'h0101, 16'h0020);
    rd(CMD_STATUS_BYTE, 16'h0010, 16'hffff);
    rd(CMD_STATUS_WORD, 16'h4010, 16'hffff);
    rd(CMD_STATUS_IOUT, 16'h0080, 16'h0080);
    chk({13'h0000, fault_act, cur_limit}, 16'h0003);
    wr(CMD_OC_LV_ACT, 16'h00c0);
    wr(CMD_OC_LV_LIM, 16'h0200);
    meas(16'h0100, 16'h0101, 16'h0020);
    rd(CMD_STATUS_IOUT, 16'h0040, 16'h0040);
    chk({13'h0000, fault_act, out_off}, 16'h0007);
    idle();
    // overcurrent warning
    wr(CMD_IOUT_OCW_LIM, 16'h0080);
    meas(16'h1000, 16'h0090, 16'h0020);
    rd(CMD_STATUS_WORD, 16'h4001, 16'hffff);
    rd(CMD_STATUS_IOUT, 16'h0020, 16'hffff);
    chk({14'h0000, fault_alert, warn_alert}, 16'h0001);
    idle();
    // sink current
    wr(CMD_SINK_ACT, 16'h00c0);
    wr(CMD_SINK_LIM, 16'h0010);
    meas(16'h1000, 16'hfff0, 16'h0020);
    rd(CMD_STATUS_IOUT, 16'h0000, 16'hffff);
    meas(16'h1000, 16'hffef, 16'h0020);
    rd(CMD_STATUS_IOUT, 16'h0010, 16'hffff);
    rd(CMD_STATUS_WORD, 16'h4001, 16'hffff);
    chk({14'h0000, out_off, sync_rect_off}, 16'h0001);
    idle();
    // undervoltage masking
    wr(CMD_VOUT_UV_LIM, 16'h0100);
    unit_en = 1'b1;
    meas(16'h0050, 16'h0000, 16'h0020);
    rd(CMD_STATUS_VOUT, 16'h0000, 16'hffff);
    vout_in_reg = 1'b1;
    meas(16'h0050, 16'h0000, 16'h0020);
    rd(CMD_STATUS_VOUT, 16'h0010, 16'hffff);
    rd(CMD_STATUS_WORD, 16'h8001, 16'hffff);
    chk({15'h0000, fault_alert}, 16'h0001);
    unit_en = 1'b0;
    meas(16'h0050, 16'h0000, 16'h0020);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    rd(CMD_STATUS_VOUT, 16'h0000, 16'hffff);
    vout_in_reg = 1'b0;
    idle();
    // temperature
    wr(CMD_OT_LIM, 16'h0050);
    meas(16'h1000, 16'h0000, 16'h0050);
    rd(CMD_STATUS_TEMP, 16'h0000, 16'hffff);
    meas(16'h1000, 16'h0000, 16'h0060);
    rd(CMD_STATUS_TEMP, 16'h0080, 16'hffff);
    rd(CMD_STATUS_BYTE, 16'h0004, 16'hffff);
    idle();
    wr(CMD_OTW_LIM, 16'h0040);
    meas(16'h1000, 16'h0000, 16'h0045);
    rd(CMD_STATUS_TEMP, 16'h0040, 16'hffff);
    chk({15'h0000, warn_alert}, 16'h0001);
    idle();
    wr(CMD_UTW_LIM, 16'hfff0);
    wr(CMD_UT_LIM, 16'hffd0);
    wr(CMD_UT_ACT, 16'h0080);
    meas(16'h1000, 16'h0000, 16'hffe0);
    rd(CMD_STATUS_TEMP, 16'h0020, 16'hffff);
    meas(16'h1000, 16'h0000, 16'hffc0);
    rd(CMD_STATUS_TEMP, 16'h0030, 16'hffff);
    chk({14'h0000, fault_act}, 16'h0002);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    rd(CMD_STATUS_TEMP, 16'h0030, 16'hffff);
    idle();
    rd(CMD_STATUS_TEMP, 16'h0000, 16'hffff);
    rd(CMD_STATUS_BYTE, 16'h0000, 16'hffff);
    chk({15'h0000, fault_alert}, 16'h0000);
    // delayed shutdown, one delay unit
    wr(CMD_UT_ACT, 16'h0081);
    meas(16'h1000, 16'h0000, 16'hffc0);
    repeat (DELAY_UNIT_CYC - 20) @(negedge clk);
    chk({13'h0000, fault_act, out_off}, 16'h0000);
    repeat (40) @(negedge clk);
    chk({13'h0000, fault_act, out_off}, 16'h0005);
    idle();
    end_sim();
  end
endmodule
